//--- hdl/target_interface_unit.sv
`timescale 1ns/1ns
module target_interface_unit
    import pci_target_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h0f0f, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h00a5 // arbitrary value
)(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // bus inputs
    input wire logic [31:0] i_ad,
    input wire logic [3:0] i_cbe_n,
    input wire logic i_frame_n,
    input wire logic i_irdy_n,
    input wire logic i_idsel,
    // bus target drive
    output logic [31:0] o_ad,
    output logic o_ad_oe,
    output logic o_devsel_n,
    output logic o_devsel_oe,
    output logic o_trdy_n,
    output logic o_trdy_oe,
    output logic o_stop_n,
    output logic o_stop_oe,
    // device status
    input wire logic i_eeprom_busy,
    // resource side
    output logic o_res_rd,
    output logic o_res_wr,
    output logic [2:0] o_res_sel,
    output logic [RES_ADDR_W-1:0] o_res_addr,
    output logic [31:0] o_res_wdata,
    output logic [3:0] o_res_be,
    input wire logic [31:0] i_res_rdata
);
    typedef enum logic [2:0] {
        ST_IDLE, ST_CLAIM, ST_DEVSEL, ST_DATA, ST_DISC, ST_RETRY, ST_TURN
    } state_type;

    state_type state_reg;
    state_type state_next;
    logic frame_prev_reg;
    logic acc_write_reg;
    logic acc_cfg_reg;
    logic [2:0] acc_sel_reg;
    logic [RES_ADDR_W-1:0] acc_addr_reg;
    logic [31:0] ad_reg;
    logic ad_oe_reg;
    logic devsel_n_reg;
    logic trdy_n_reg;
    logic stop_n_reg;
    logic drive_reg;
    logic res_rd_reg;
    logic res_wr_reg;
    logic [31:0] res_wdata_reg;
    logic [3:0] res_be_reg;

    // decode results and configuration state
    logic hit;
    logic dec_write;
    logic dec_cfg;
    logic [2:0] dec_sel;
    logic io_en;
    logic mem_en;
    logic [26:0] io_base;
    logic [26:0] mem_base;
    logic [11:0] rom_base;
    logic rom_en;
    logic [31:0] cfg_rdata;

    // address phase: frame newly low, also straight out of a turnaround
    wire may_start = (state_reg == ST_IDLE) || (state_reg == ST_TURN);
    wire start = may_start && frame_prev_reg && !i_frame_n;
    wire claim = start && hit;
    wire xfer = (state_reg == ST_DATA) && !i_irdy_n;
    wire burst_early = (state_reg == ST_DEVSEL) && !i_frame_n
        && !i_irdy_n;
    wire [5:0] cfg_index = acc_addr_reg[7:2];
    wire cfg_we = xfer && acc_write_reg && acc_cfg_reg;
    wire res_rd_next = (state_reg == ST_CLAIM) && !i_eeprom_busy
        && !acc_write_reg && !acc_cfg_reg;
    // the reset register takes no writes
    wire res_wr_next = xfer && acc_write_reg && !acc_cfg_reg
        && (acc_sel_reg != SEL_RESET);
    wire [31:0] rd_data = acc_cfg_reg ? cfg_rdata : i_res_rdata;

    pci_cmd_decode u_decode (
        .i_cmd(~i_cbe_n),
        .i_addr(i_ad),
        .i_idsel(i_idsel),
        .i_io_en(io_en),
        .i_mem_en(mem_en),
        .i_io_base(io_base),
        .i_mem_base(mem_base),
        .i_rom_base(rom_base),
        .i_rom_en(rom_en),
        .o_hit(hit),
        .o_write(dec_write),
        .o_cfg(dec_cfg),
        .o_sel(dec_sel)
    );

    pci_cfg_space #(
        .VENDOR_CODE(VENDOR_CODE),
        .PART_CODE(PART_CODE)
    ) u_cfg (
        .i_clock(i_clock),
        .i_rst(i_rst),
        .i_clk_en(i_clk_en),
        .i_we(cfg_we),
        .i_index(cfg_index),
        .i_wdata(i_ad),
        .i_be(~i_cbe_n),
        .o_rdata(cfg_rdata),
        .o_io_en(io_en),
        .o_mem_en(mem_en),
        .o_io_base(io_base),
        .o_mem_base(mem_base),
        .o_rom_base(rom_base),
        .o_rom_en(rom_en)
    );

    // target sequence; devsel one clock after the decode clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE, ST_TURN: begin
                state_next = claim ? ST_CLAIM : ST_IDLE;
            end
            ST_CLAIM: begin
                // loader owns the registers, so push the master back
                state_next = i_eeprom_busy ? ST_RETRY : ST_DEVSEL;
            end
            ST_DEVSEL: begin
                state_next = ST_DATA;
            end
            ST_DATA: begin
                if (xfer) begin
                    state_next = i_frame_n ? ST_TURN : ST_DISC;
                end
            end
            ST_DISC, ST_RETRY: begin
                // stop stays until the master drops frame
                if (i_frame_n) begin
                    state_next = ST_TURN;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    // pin levels for the next clock
    wire claimed_next = (state_next == ST_DEVSEL)
        || (state_next == ST_DATA) || (state_next == ST_DISC)
        || (state_next == ST_RETRY);
    wire stop_keep = (state_reg == ST_DEVSEL) ? burst_early : !stop_n_reg;
    wire stop_next = (state_next == ST_DISC) || (state_next == ST_RETRY)
        || ((state_next == ST_DATA) && stop_keep);
    wire drive_next = claimed_next || (state_next == ST_TURN);
    wire ad_oe_next = !acc_write_reg && ((state_next == ST_DEVSEL)
        || (state_next == ST_DATA));

    // sequence state and the pending access
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_reg <= ST_IDLE;
            frame_prev_reg <= 1'b1;
            acc_write_reg <= 1'b0;
            acc_cfg_reg <= 1'b0;
            acc_sel_reg <= SEL_PROM;
            acc_addr_reg <= '0;
        end else if (i_clk_en) begin
            state_reg <= state_next;
            frame_prev_reg <= i_frame_n;
            if (claim) begin
                acc_write_reg <= dec_write;
                acc_cfg_reg <= dec_cfg;
                acc_sel_reg <= dec_sel;
                acc_addr_reg <= i_ad[RES_ADDR_W-1:0];
            end
        end
    end

    // bus pins; strobes are driven high for a clock before release
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            devsel_n_reg <= 1'b1;
            trdy_n_reg <= 1'b1;
            stop_n_reg <= 1'b1;
            drive_reg <= 1'b0;
            ad_oe_reg <= 1'b0;
            ad_reg <= 32'h0;
        end else if (i_clk_en) begin
            devsel_n_reg <= !claimed_next;
            trdy_n_reg <= !(state_next == ST_DATA);
            stop_n_reg <= !stop_next;
            drive_reg <= drive_next;
            ad_oe_reg <= ad_oe_next;
            if (state_reg == ST_DEVSEL) begin
                ad_reg <= rd_data;
            end
        end
    end

    // resource strobes, one clock each
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            res_rd_reg <= 1'b0;
            res_wr_reg <= 1'b0;
            res_wdata_reg <= 32'h0;
            res_be_reg <= 4'h0;
        end else if (i_clk_en) begin
            res_rd_reg <= res_rd_next;
            res_wr_reg <= res_wr_next;
            if (xfer) begin
                res_wdata_reg <= i_ad;
                res_be_reg <= ~i_cbe_n;
            end
        end
    end

    assign o_ad = ad_reg;
    assign o_ad_oe = ad_oe_reg;
    assign o_devsel_n = devsel_n_reg;
    assign o_trdy_n = trdy_n_reg;
    assign o_stop_n = stop_n_reg;
    assign o_devsel_oe = drive_reg;
    assign o_trdy_oe = drive_reg;
    assign o_stop_oe = drive_reg;
    assign o_res_rd = res_rd_reg;
    assign o_res_wr = res_wr_reg;
    assign o_res_sel = acc_sel_reg;
    assign o_res_addr = acc_addr_reg;
    assign o_res_wdata = res_wdata_reg;
    assign o_res_be = res_be_reg;

    // checks below assume the enable stays high over the watched span
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_rst);

    sequence s_claim;
        i_clk_en && claim;
    endsequence

    sequence s_ready;
        i_clk_en && !i_eeprom_busy;
    endsequence

    sequence s_busy;
        i_clk_en && i_eeprom_busy;
    endsequence

    AST_DEVSEL_MEDIUM:
        assert property (s_claim |=> o_devsel_n && i_clk_en
            ##1 !o_devsel_n)
        else $error("devsel not on second clock after frame");

    AST_TRDY_THIRD:
        assert property (s_claim ##1 s_ready ##1 i_clk_en
            |=> !o_trdy_n && !o_devsel_n)
        else $error("trdy not on third clock of data phase");

    AST_BUSY_RETRY:
        assert property (s_claim ##1 s_busy
            |=> !o_devsel_n && !o_stop_n && o_trdy_n)
        else $error("busy access not retried");

    AST_RETRY_HOLD:
        assert property (i_clk_en && state_reg == ST_RETRY && !i_frame_n
            |=> !o_stop_n && o_trdy_n && !o_devsel_n)
        else $error("stop released before frame");

    AST_BURST_EARLY:
        assert property (i_clk_en && burst_early
            |=> !o_trdy_n && !o_stop_n)
        else $error("early burst stop missing");

    AST_BURST_DISC:
        assert property (i_clk_en && xfer && !i_frame_n
            |=> o_trdy_n && !o_stop_n && !o_devsel_n)
        else $error("burst not disconnected");

    AST_CFG_SELECT:
        assert property (i_clk_en && start && i_cbe_n[3:1] == 3'b010
            && (!i_idsel || i_ad[1:0] != 2'h0) |=> state_reg != ST_CLAIM)
        else $error("configuration claimed without select");

    AST_RSVD_IGNORED:
        assert property (i_clk_en && start && (~i_cbe_n == 4'h0
            || ~i_cbe_n == 4'h1 || ~i_cbe_n == 4'h4 || ~i_cbe_n == 4'h5
            || ~i_cbe_n == 4'h8 || ~i_cbe_n == 4'h9 || ~i_cbe_n == 4'hd)
            |=> state_reg != ST_CLAIM)
        else $error("unused command claimed");

    AST_FBB_ONE:
        assert property (i_clk_en && state_reg == ST_DEVSEL && acc_cfg_reg
            && !acc_write_reg && cfg_index == CFG_IDX_CMD
            |=> o_ad[STAT_FBB_BIT])
        else $error("fast back-to-back bit not one");

    AST_BACK_TO_BACK:
        assert property (i_clk_en && state_reg == ST_TURN && !i_frame_n
            && hit |=> state_reg == ST_CLAIM)
        else $error("back-to-back address phase missed");

    AST_RES_WRITE:
        assert property (i_clk_en && xfer && acc_write_reg && !acc_cfg_reg
            && acc_sel_reg != SEL_RESET
            |=> o_res_wr && o_res_wdata == $past(i_ad))
        else $error("register write strobe or data wrong");
endmodule

//--- include/pci_target_pkg.sv
package pci_target_pkg;
    // bus command codes
    localparam logic [3:0] CMD_IO_RD = 4'h2;
    localparam logic [3:0] CMD_IO_WR = 4'h3;
    localparam logic [3:0] CMD_MEM_RD = 4'h6;
    localparam logic [3:0] CMD_MEM_WR = 4'h7;
    localparam logic [3:0] CMD_CFG_RD = 4'ha;
    localparam logic [3:0] CMD_CFG_WR = 4'hb;
    localparam logic [3:0] CMD_MEM_RD_MULT = 4'hc;
    localparam logic [3:0] CMD_MEM_RD_LINE = 4'he;
    localparam logic [3:0] CMD_MEM_WR_INV = 4'hf;
    // configuration dword indices
    localparam logic [5:0] CFG_IDX_ID = 6'h00;
    localparam logic [5:0] CFG_IDX_CMD = 6'h01;
    localparam logic [5:0] CFG_IDX_CLASS = 6'h02;
    localparam logic [5:0] CFG_IDX_IO_BAR = 6'h04;
    localparam logic [5:0] CFG_IDX_MEM_BAR = 6'h05;
    localparam logic [5:0] CFG_IDX_ROM_BAR = 6'h0c;
    // field positions
    localparam int CMD_IO_EN_BIT = 0;
    localparam int CMD_MEM_EN_BIT = 1;
    localparam int STAT_FBB_BIT = 23;
    localparam int WIN_LSB = 5;
    localparam int ROM_LSB = 20;
    localparam int RES_ADDR_W = 20;
    // reset values
    localparam logic [1:0] CMD_RESET = 2'h0;
    localparam logic [26:0] BAR_RESET = 27'h0;
    localparam logic [11:0] ROM_BASE_RESET = 12'h000;
    // resource selects
    localparam logic [2:0] SEL_PROM = 3'h0;
    localparam logic [2:0] SEL_CTRL = 3'h1;
    localparam logic [2:0] SEL_BOARD = 3'h2;
    localparam logic [2:0] SEL_RESET = 3'h3;
    localparam logic [2:0] SEL_EXP = 3'h4;
    // window offsets above the station address bytes
    localparam logic [2:0] OFS_RESET_BOARD = 3'h5;
endpackage

//--- hdl/pci_cmd_decode.sv
`timescale 1ns/1ns
module pci_cmd_decode
    import pci_target_pkg::*;
(
    // address phase
    input wire logic [3:0] i_cmd,
    input wire logic [31:0] i_addr,
    input wire logic i_idsel,
    // configuration state
    input wire logic i_io_en,
    input wire logic i_mem_en,
    input wire logic [26:0] i_io_base,
    input wire logic [26:0] i_mem_base,
    input wire logic [11:0] i_rom_base,
    input wire logic i_rom_en,
    // decode result
    output logic o_hit,
    output logic o_write,
    output logic o_cfg,
    output logic [2:0] o_sel
);
    // 32-byte window compare, shared by io and memory space
    function automatic logic win_match(logic [31:0] a, logic [26:0] b);
        win_match = (a[31:WIN_LSB] == b);
    endfunction

    wire io_rd = (i_cmd == CMD_IO_RD);
    wire io_wr = (i_cmd == CMD_IO_WR);
    // read aliases fold onto the plain memory read
    wire mem_rd = (i_cmd == CMD_MEM_RD) || (i_cmd == CMD_MEM_RD_MULT)
        || (i_cmd == CMD_MEM_RD_LINE);
    wire mem_wr = (i_cmd == CMD_MEM_WR) || (i_cmd == CMD_MEM_WR_INV);
    wire cfg_rd = (i_cmd == CMD_CFG_RD);
    wire cfg_wr = (i_cmd == CMD_CFG_WR);
    // every other code matches none of the terms and is never claimed
    wire io_hit = i_io_en && (io_rd || io_wr)
        && win_match(i_addr, i_io_base);
    wire mem_hit = i_mem_en && (mem_rd || mem_wr)
        && win_match(i_addr, i_mem_base);
    wire rom_hit = i_mem_en && i_rom_en && mem_rd
        && (i_addr[31:ROM_LSB] == i_rom_base);
    wire cfg_hit = i_idsel && (i_addr[1:0] == 2'h0)
        && (cfg_rd || cfg_wr);
    wire in_upper = i_addr[4];
    wire rst_or_board = (i_addr[4:2] == OFS_RESET_BOARD);
    wire [2:0] win_sel = !in_upper ? SEL_PROM
        : rst_or_board ? (i_addr[1] ? SEL_BOARD : SEL_RESET) : SEL_CTRL;

    // register window wins over an overlapping rom window
    assign o_hit = io_hit || mem_hit || rom_hit || cfg_hit;
    assign o_write = io_wr || mem_wr || cfg_wr;
    assign o_cfg = cfg_hit;
    assign o_sel = (io_hit || mem_hit) ? win_sel : SEL_EXP;
endmodule

//--- hdl/pci_cfg_space.sv
`timescale 1ns/1ns
module pci_cfg_space
    import pci_target_pkg::*;
#(
    parameter logic [15:0] VENDOR_CODE = 16'h0f0f, // arbitrary value
    parameter logic [15:0] PART_CODE = 16'h00a5, // arbitrary value
    parameter logic [31:0] CLASS_REV = 32'h02000000
)(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_clk_en,
    // access port
    input wire logic i_we,
    input wire logic [5:0] i_index,
    input wire logic [31:0] i_wdata,
    input wire logic [3:0] i_be,
    output logic [31:0] o_rdata,
    // decoded settings
    output logic o_io_en,
    output logic o_mem_en,
    output logic [26:0] o_io_base,
    output logic [26:0] o_mem_base,
    output logic [11:0] o_rom_base,
    output logic o_rom_en
);
    // byte-lane merge of a write into an old dword
    function automatic logic [31:0] merge(logic [31:0] o, logic [31:0] n,
            logic [3:0] be);
        for (int k = 0; k < 4; k++) begin
            o[k*8 +: 8] = be[k] ? n[k*8 +: 8] : o[k*8 +: 8];
        end
        merge = o;
    endfunction

    logic [1:0] cmd_reg;
    logic [26:0] io_base_reg;
    logic [26:0] mem_base_reg;
    logic [11:0] rom_base_reg;
    logic rom_en_reg;

    wire [31:0] cmd_word = {8'h00, 8'h80, 14'h0, cmd_reg};
    wire [31:0] io_word = {io_base_reg, 5'h01};
    wire [31:0] mem_word = {mem_base_reg, 5'h00};
    wire [31:0] rom_word = {rom_base_reg, 19'h0, rom_en_reg};
    wire [31:0] cmd_new = merge(cmd_word, i_wdata, i_be);
    wire [31:0] io_new = merge(io_word, i_wdata, i_be);
    wire [31:0] mem_new = merge(mem_word, i_wdata, i_be);
    wire [31:0] rom_new = merge(rom_word, i_wdata, i_be);

    // unimplemented dwords read as zero
    assign o_rdata = (i_index == CFG_IDX_ID) ? {PART_CODE, VENDOR_CODE}
        : (i_index == CFG_IDX_CMD) ? cmd_word
        : (i_index == CFG_IDX_CLASS) ? CLASS_REV
        : (i_index == CFG_IDX_IO_BAR) ? io_word
        : (i_index == CFG_IDX_MEM_BAR) ? mem_word
        : (i_index == CFG_IDX_ROM_BAR) ? rom_word : 32'h0;
    assign o_io_en = cmd_reg[CMD_IO_EN_BIT];
    assign o_mem_en = cmd_reg[CMD_MEM_EN_BIT];
    assign o_io_base = io_base_reg;
    assign o_mem_base = mem_base_reg;
    assign o_rom_base = rom_base_reg;
    assign o_rom_en = rom_en_reg;

    // only the two command enable bits, the base bits of each bar, and the rom bar enable bit, are writable
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            cmd_reg <= CMD_RESET;
            io_base_reg <= BAR_RESET;
            mem_base_reg <= BAR_RESET;
            rom_base_reg <= ROM_BASE_RESET;
            rom_en_reg <= 1'b0;
        end else if (i_clk_en && i_we) begin
            if (i_index == CFG_IDX_CMD) cmd_reg <= cmd_new[1:0];
            if (i_index == CFG_IDX_IO_BAR) io_base_reg <= io_new[31:5];
            if (i_index == CFG_IDX_MEM_BAR) mem_base_reg <= mem_new[31:5];
            if (i_index == CFG_IDX_ROM_BAR) begin
                rom_base_reg <= rom_new[31:20];
                rom_en_reg <= rom_new[0];
            end
        end
    end
endmodule

//--- verif/pci_host_model.sv
`timescale 1ns/1ns
module pci_host_model (
    // bus clock
    input wire logic i_clock,
    // wire levels, released target control lines already pulled up
    input wire logic [31:0] i_ad,
    input wire logic i_devsel_n,
    input wire logic i_trdy_n,
    input wire logic i_stop_n,
    // initiator drive
    output logic [31:0] o_ad,
    output logic o_ad_oe,
    output logic [3:0] o_cbe_n,
    output logic o_frame_n,
    output logic o_irdy_n,
    output logic o_idsel
);
    // bus idle at time zero
    initial begin
        o_ad = 32'h0;
        o_ad_oe = 1'b0;
        o_cbe_n = 4'hf;
        o_frame_n = 1'b1;
        o_irdy_n = 1'b1;
        o_idsel = 1'b0;
    end

    // one transaction; reports the edge count of devsel, trdy and stop
    task automatic xfer(input logic [3:0] cmd, input logic [31:0] addr,
        input logic [31:0] wdata, input logic [3:0] be, input logic sel,
        input logic burst, output int dn, output int tn, output int sn,
        output logic [31:0] rdata);
        int n;
        dn = 0;
        tn = 0;
        sn = 0;
        rdata = 32'h0;
        o_frame_n <= 1'b0;
        o_ad <= addr;
        o_ad_oe <= 1'b1;
        o_cbe_n <= ~cmd;
        o_idsel <= sel;
        @(posedge i_clock);
        // a burst keeps frame low into the data phase
        o_frame_n <= ~burst;
        o_irdy_n <= 1'b0;
        o_cbe_n <= ~be;
        o_idsel <= 1'b0;
        o_ad <= wdata;
        o_ad_oe <= cmd[0];
        for (n = 1; n <= 8; n++) begin
            @(posedge i_clock);
            if (dn == 0 && i_devsel_n === 1'b0)
                dn = n;
            if (sn == 0 && i_stop_n === 1'b0)
                sn = n;
            if (i_trdy_n === 1'b0) begin
                tn = n;
                rdata = i_ad;
                break;
            end
            // stop ends it; no devsel by then is a master abort
            if (sn != 0 || (n == 6 && dn == 0))
                break;
        end
        // frame goes first, irdy one clock later
        if (o_frame_n == 1'b0) begin
            o_frame_n <= 1'b1;
            @(posedge i_clock);
        end
        o_irdy_n <= 1'b1;
        // reads leave ad released, so back to back needs no re-drive
        if (cmd[0])
            o_ad_oe <= 1'b0;
    endtask
endmodule

//--- verif/tb.sv
`timescale 1ns/1ns
module tb;
    import pci_target_pkg::*;
    localparam logic [15:0] VEND = 16'h5a5a; // arbitrary value
    localparam logic [15:0] PART = 16'h0c3c; // arbitrary value
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic busy = 1'b1;
    logic tick = 1'b0;
    logic [31:0] h_ad, t_ad, ad_w, rd, res_rdata, res_wdata, wr_info;
    logic [3:0] h_cbe_n, res_be;
    logic h_ad_oe, h_frame_n, h_irdy_n, h_idsel, t_ad_oe, res_rd, res_wr;
    logic t_devsel_n, t_devsel_oe, t_trdy_n, t_trdy_oe, t_stop_n, t_stop_oe;
    logic [2:0] res_sel;
    logic [RES_ADDR_W-1:0] res_addr;
    int dn, tn, sn, wr_cnt, err_total, total_checks;
    initial wr_cnt = 0;
    initial err_total = 0;
    initial total_checks = 0;

    // undriven ad toggles so a stale value never matches
    assign ad_w = t_ad_oe ? t_ad : (h_ad_oe ? h_ad : {32{tick}});
    assign res_rdata = res_rd ? {9'h0, res_sel, res_addr} : {32{~tick}};
    always #50 clock = ~clock;
    always @(posedge clock) tick <= ~tick;

    // resource write log, sampled in the pulse cycle
    always @(posedge clock) begin
        if (res_wr === 1'b1) begin
            wr_cnt++;
            wr_info = {5'h0, res_sel, res_addr, res_be};
        end
    end

    target_interface_unit #(.VENDOR_CODE(VEND), .PART_CODE(PART))
    u_target_interface_unit (
        .i_clock(clock), .i_rst(rst), .i_clk_en(1'b1), .i_ad(ad_w),
        .i_cbe_n(h_cbe_n), .i_frame_n(h_frame_n), .i_irdy_n(h_irdy_n),
        .i_idsel(h_idsel), .o_ad(t_ad), .o_ad_oe(t_ad_oe),
        .o_devsel_n(t_devsel_n), .o_devsel_oe(t_devsel_oe),
        .o_trdy_n(t_trdy_n), .o_trdy_oe(t_trdy_oe), .o_stop_n(t_stop_n),
        .o_stop_oe(t_stop_oe), .i_eeprom_busy(busy), .o_res_rd(res_rd),
        .o_res_wr(res_wr), .o_res_sel(res_sel), .o_res_addr(res_addr),
        .o_res_wdata(res_wdata), .o_res_be(res_be), .i_res_rdata(res_rdata));

    // pci control lines are pulled up when no target drives them
    pci_host_model u_pci_host_model (
        .i_clock(clock), .i_ad(ad_w),
        .i_devsel_n(t_devsel_oe ? t_devsel_n : 1'b1),
        .i_trdy_n(t_trdy_oe ? t_trdy_n : 1'b1),
        .i_stop_n(t_stop_oe ? t_stop_n : 1'b1),
        .o_ad(h_ad), .o_ad_oe(h_ad_oe), .o_cbe_n(h_cbe_n),
        .o_frame_n(h_frame_n), .o_irdy_n(h_irdy_n), .o_idsel(h_idsel));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("mismatch at %0t: got %h exp %h", $time, got, exp);
            err_total++;
        end
    endtask

    // one idle clock, then a transaction
    task automatic go(input logic [3:0] cmd, input logic [31:0] addr,
        input logic [31:0] wd, input logic [3:0] be, input logic sel);
        @(posedge clock);
        u_pci_host_model.xfer(cmd, addr, wd, be, sel, 1'b0, dn, tn, sn, rd);
    endtask

    task automatic t_busy;
        go(CMD_CFG_RD, 32'h0, 32'h0, 4'hf, 1'b1);
        check(dn, 2);
        check(sn, 2);
        check(tn, 0);
        // frame held low keeps the retry stop up until frame rises
        @(posedge clock);
        u_pci_host_model.xfer(CMD_CFG_RD, 32'h0, 32'h0, 4'hf, 1'b1, 1'b1,
            dn, tn, sn, rd);
        check(sn, 2);
        check(tn, 0);
        busy <= 1'b0;
    endtask

    task automatic t_cfg;
        go(CMD_CFG_RD, 32'hffff_ff00, 32'h0, 4'hf, 1'b1);
        check(dn, 2);
        check(tn, 3);
        check(rd, {PART, VEND});
        go(CMD_CFG_RD, 32'h4, 32'h0, 4'hf, 1'b1);
        check(rd, 32'h0080_0000);
        go(CMD_CFG_WR, 32'h10, 32'h0000_1200, 4'hf, 1'b1);
        check(tn, 3);
        go(CMD_CFG_WR, 32'h10, 32'hffff_ffff, 4'h1, 1'b1);
        go(CMD_CFG_RD, 32'h10, 32'h0, 4'hf, 1'b1);
        check(rd, 32'h0000_12e1);
        go(CMD_CFG_RD, 32'h11, 32'h0, 4'hf, 1'b1);
        check(dn, 0);
        go(CMD_CFG_RD, 32'h0, 32'h0, 4'hf, 1'b0);
        check(dn, 0);
    endtask

    task automatic t_io;
        logic [4:0] ofs [6] = '{5'h00, 5'h0f, 5'h10, 5'h14, 5'h16, 5'h1f};
        logic [2:0] sel [6] = '{SEL_PROM, SEL_PROM, SEL_CTRL, SEL_RESET,
            SEL_BOARD, SEL_CTRL};
        int c;
        go(CMD_IO_RD, 32'h12e0, 32'h0, 4'hf, 1'b0);
        check(dn, 0);
        go(CMD_CFG_WR, 32'h14, 32'h8000_0000, 4'hf, 1'b1);
        go(CMD_CFG_WR, 32'h30, 32'h0010_0001, 4'hf, 1'b1);
        go(CMD_CFG_WR, 32'h4, 32'h3, 4'hf, 1'b1);
        for (int i = 0; i < 6; i++) begin
            go(CMD_IO_RD, 32'h12e0 + ofs[i], 32'h0, 4'hf, 1'b0);
            check(rd, {9'h0, sel[i], 15'h0097, ofs[i]});
        end
        go(CMD_IO_RD, 32'h1300, 32'h0, 4'hf, 1'b0);
        check(dn, 0);
        go(CMD_IO_WR, 32'h12f6, 32'hcafe_f00d, 4'h3, 1'b0);
        repeat (2) @(posedge clock);
        check(wr_info, {5'h0, SEL_BOARD, 20'h012f6, 4'h3});
        check(u_target_interface_unit.o_res_wdata, 32'hcafe_f00d);
        c = wr_cnt;
        // the reset register takes no write strobe
        go(CMD_IO_WR, 32'h12f4, 32'h1, 4'hf, 1'b0);
        repeat (2) @(posedge clock);
        check(wr_cnt, c);
    endtask

    task automatic t_mem;
        logic [3:0] rc [3] = '{CMD_MEM_RD, CMD_MEM_RD_MULT, CMD_MEM_RD_LINE};
        for (int i = 0; i < 3; i++) begin
            go(rc[i], 32'h8000_0010, 32'h0, 4'hf, 1'b0);
            check(rd, {9'h0, SEL_CTRL, 20'h00010});
            go(rc[i], 32'h0017_fff0, 32'h0, 4'hf, 1'b0);
            check(rd, {9'h0, SEL_EXP, 20'h7fff0});
        end
        go(CMD_MEM_WR, 32'h8000_0018, 32'h0, 4'hc, 1'b0);
        repeat (2) @(posedge clock);
        check(wr_info, {5'h0, SEL_CTRL, 20'h00018, 4'hc});
        go(CMD_MEM_WR_INV, 32'h8000_0008, 32'h0, 4'h1, 1'b0);
        repeat (2) @(posedge clock);
        check(wr_info, {5'h0, SEL_PROM, 20'h00008, 4'h1});
    endtask

    task automatic t_refused;
        logic [3:0] bad [7] = '{4'h0, 4'h1, 4'h4, 4'h5, 4'h8, 4'h9, 4'hd};
        for (int i = 0; i < 7; i++) begin
            go(bad[i], 32'h12e0, 32'h0, 4'hf, 1'b1);
            check(dn, 0);
        end
    endtask

    // burst, then an unclaimed read chained straight into two claims
    task automatic t_burst_b2b;
        @(posedge clock);
        u_pci_host_model.xfer(CMD_CFG_RD, 32'h0, 32'h0, 4'hf, 1'b1, 1'b1,
            dn, tn, sn, rd);
        check(tn, 3);
        check(sn, 3);
        check(rd, {PART, VEND});
        @(posedge clock);
        u_pci_host_model.xfer(CMD_IO_RD, 32'h4000_0000, 32'h0, 4'hf, 1'b0,
            1'b0, dn, tn, sn, rd);
        for (int i = 0; i < 2; i++) begin
            u_pci_host_model.xfer(CMD_CFG_RD, 32'h4, 32'h0, 4'hf, 1'b1, 1'b0,
                dn, tn, sn, rd);
            check(dn, 2);
            check(rd, 32'h0080_0003);
        end
    endtask

    task automatic close_out;
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // hang guard, far beyond the few hundred clocks the tests need
    initial begin
        #(100 * 5000);
        err_total++;
        close_out;
    end

    initial begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        t_busy;
        t_cfg;
        t_io;
        t_mem;
        t_refused;
        t_burst_b2b;
        close_out;
    end
endmodule
